//--- verilog/kgp_map.svh
// Purpose: Register offsets, field positions and reset values for the key-scan ports
// Assumes: Nibble-wide register file and data memory, 25 MHz core clock
// Notes: Included by the port module; definitions only
`ifndef KGP_MAP_SVH
`define KGP_MAP_SVH
`define KGP_RF_POL      6'h05
`define KGP_RF_A_KEY    6'h06
`define KGP_RF_A_RES    6'h07
`define KGP_RF_E_KEY    6'h16
`define KGP_RF_E_PU     6'h17
`define KGP_RF_SEL      6'h1F
`define KGP_RF_A_DIR    6'h25
`define KGP_RF_E_DIR    6'h27
`define KGP_DM_E        7'h6F
`define KGP_DM_A        7'h70
`define KGP_DM_B        7'h71
`define KGP_SEL_BIT     1
`define KGP_B_RES_BIT   0
`define KGP_B_KEY_BIT   1
`define KGP_B_HL_BIT    2
`define KGP_NIB_RST     4'h0
`define KGP_TRI_RST     3'h0
`define KGP_BIT_RST     1'b0
`define KGP_NIB_ZERO    4'h0
`endif

//--- verilog/kgp_pkg.sv
// Purpose: Shared types for the key-scan ports
// Assumes: Four-bit data path
// Notes: Constants live in the map header
`default_nettype none
package kgp_pkg;
  typedef logic [3:0] kgp_nib_t;
  typedef enum logic {
    KGP_BANK0 = 1'b0,
    KGP_BANK1 = 1'b1
  } kgp_bank_e;
endpackage
`default_nettype wire

//--- verilog/kgp_ports.sv
// Purpose: Key-scan ports E (4 bit), A (3 bit) and B (1 bit, shared pin)
// Assumes: Pins are asynchronous and pass two flip-flops; one core clock
// Notes: Read data appears one clock after the address; pin controls lag config by one clock
`include "kgp_map.svh"
`default_nettype none
module kgp_ports
  import kgp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rf_wr,
  input  wire logic [5:0] rf_addr,
  input  wire logic [3:0] rf_wdata,
  output var  logic [3:0] rf_rdata,
  input  wire logic       dm_wr,
  input  wire logic       dm_bank,
  input  wire logic [6:0] dm_addr,
  input  wire logic [3:0] dm_wdata,
  output var  logic [3:0] dm_rdata,
  input  wire logic [3:0] porte_pin_i,
  output var  logic [3:0] porte_pin_o,
  output var  logic [3:0] porte_pin_oe,
  output var  logic [3:0] porte_pullup,
  input  wire logic [2:0] porta_pin_i,
  output var  logic [2:0] porta_pin_o,
  output var  logic [2:0] porta_pin_oe,
  output var  logic [2:0] porta_pullup,
  output var  logic [2:0] porta_pulldown,
  input  wire logic       shared_pin_i,
  output var  logic       portb_pullup,
  output var  logic       portb_pulldown,
  output var  logic       ext_int_edge,
  output var  logic       standby_release
);

  kgp_nib_t   porte_direction_q;
  kgp_nib_t   porte_keymatrix_select_q;
  kgp_nib_t   porte_pullup_enable_q;
  kgp_nib_t   porte_latch_q;
  logic [2:0] porta_direction_q;
  logic [2:0] porta_keymatrix_select_q;
  logic [2:0] porta_resistor_enable_q;
  logic [2:0] porta_latch_q;
  kgp_nib_t   polarity_cfg_q;
  logic       shared_pin_select_q;
  logic [3:0] pe_s1_q;
  logic [3:0] pe_s2_q;
  logic [2:0] pa_s1_q;
  logic [2:0] pa_s2_q;
  logic       pb_s1_q;
  logic       pb_s2_q;
  logic       pb_s3_q;
  logic       rf_hit;
  logic       dm_e_hit;
  logic       dm_a_hit;
  logic       dm_b_hit;
  logic [3:0] porte_view;
  logic [2:0] porta_view;
  logic       portb_view;
  logic       pb_res;
  logic       pb_key;
  logic       pb_hl;
  logic [3:0] pe_oe_d;
  logic [3:0] pe_o_d;
  logic [3:0] pe_pu_d;
  logic [3:0] pe_wake;
  logic [2:0] pa_oe_d;
  logic [2:0] pa_o_d;
  logic [2:0] pa_pu_d;
  logic [2:0] pa_pd_d;
  logic [2:0] pa_wake;
  logic       pb_wake;
  logic       wake_d;
  logic       edge_d;

  assign rf_hit   = rf_wr;
  assign dm_e_hit = (dm_bank == KGP_BANK0) && (dm_addr == `KGP_DM_E);
  assign dm_a_hit = (dm_bank == KGP_BANK1) && (dm_addr == `KGP_DM_A);
  assign dm_b_hit = (dm_bank == KGP_BANK1) && (dm_addr == `KGP_DM_B);

  // Register file writes; unmapped addresses are ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      porte_direction_q        <= `KGP_NIB_RST;
      porte_keymatrix_select_q <= `KGP_NIB_RST;
      porte_pullup_enable_q    <= `KGP_NIB_RST;
      porta_direction_q        <= `KGP_TRI_RST;
      porta_keymatrix_select_q <= `KGP_TRI_RST;
      porta_resistor_enable_q  <= `KGP_TRI_RST;
      polarity_cfg_q           <= `KGP_NIB_RST;
      shared_pin_select_q      <= `KGP_BIT_RST;
    end else if (rf_hit) begin
      unique case (rf_addr)
        `KGP_RF_E_DIR: porte_direction_q        <= rf_wdata;
        `KGP_RF_E_KEY: porte_keymatrix_select_q <= rf_wdata;
        `KGP_RF_E_PU:  porte_pullup_enable_q    <= rf_wdata;
        `KGP_RF_A_DIR: porta_direction_q        <= rf_wdata[2:0];
        `KGP_RF_A_KEY: porta_keymatrix_select_q <= rf_wdata[2:0];
        `KGP_RF_A_RES: porta_resistor_enable_q  <= rf_wdata[2:0];
        `KGP_RF_POL:   polarity_cfg_q           <= rf_wdata;
        `KGP_RF_SEL:   shared_pin_select_q      <= rf_wdata[`KGP_SEL_BIT];
        default: ;
      endcase
    end
  end

  // Output latches take every write, so a later switch to output shows fresh data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      porte_latch_q <= `KGP_NIB_RST;
      porta_latch_q <= `KGP_TRI_RST;
    end else if (dm_wr) begin
      if (dm_e_hit) begin
        porte_latch_q <= dm_wdata;
      end
      if (dm_a_hit) begin
        porta_latch_q <= dm_wdata[2:0];
      end
    end
  end

  // Two-stage synchronisers plus a third port B stage; the second stage feeds logic, the third only the edge detect
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pe_s1_q <= 4'h0;
      pe_s2_q <= 4'h0;
      pa_s1_q <= 3'h0;
      pa_s2_q <= 3'h0;
      pb_s1_q <= 1'b0;
      pb_s2_q <= 1'b0;
      pb_s3_q <= 1'b0;
    end else begin
      pe_s1_q <= porte_pin_i;
      pe_s2_q <= pe_s1_q;
      pa_s1_q <= porta_pin_i;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= shared_pin_i;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
    end
  end

  // Port E and A read views mix latch and pin bit by bit; port B reads its pin, zero while the interrupt owns it
  assign porte_view = (porte_direction_q & porte_latch_q) |
                      (~porte_direction_q & pe_s2_q);
  assign porta_view = (porta_direction_q & porta_latch_q) |
                      (~porta_direction_q & pa_s2_q);
  assign portb_view = pb_s2_q & ~shared_pin_select_q;

  // Register file read, one clock after the address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rf_rdata <= `KGP_NIB_ZERO;
    end else begin
      unique case (rf_addr)
        `KGP_RF_E_DIR: rf_rdata <= porte_direction_q;
        `KGP_RF_E_KEY: rf_rdata <= porte_keymatrix_select_q;
        `KGP_RF_E_PU:  rf_rdata <= porte_pullup_enable_q;
        `KGP_RF_A_DIR: rf_rdata <= {1'b0, porta_direction_q};
        `KGP_RF_A_KEY: rf_rdata <= {1'b0, porta_keymatrix_select_q};
        `KGP_RF_A_RES: rf_rdata <= {1'b0, porta_resistor_enable_q};
        `KGP_RF_POL:   rf_rdata <= polarity_cfg_q;
        `KGP_RF_SEL:   rf_rdata <= {2'b00, shared_pin_select_q, 1'b0};
        default:       rf_rdata <= `KGP_NIB_ZERO;
      endcase
    end
  end

  // Data memory read; port B is never written, writes there are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dm_rdata <= `KGP_NIB_ZERO;
    end else if (dm_e_hit) begin
      dm_rdata <= porte_view;
    end else if (dm_a_hit) begin
      dm_rdata <= {1'b0, porta_view};
    end else if (dm_b_hit) begin
      dm_rdata <= {3'b000, portb_view};
    end else begin
      dm_rdata <= `KGP_NIB_ZERO;
    end
  end

  // Port E pin control per bit
  genvar ge;
  generate
    for (ge = 0; ge < 4; ge++) begin : g_pe
      // Open drain only pulls low, so a high latch releases the pin
      assign pe_oe_d[ge] = porte_direction_q[ge] &
                           (~porte_keymatrix_select_q[ge] | ~porte_latch_q[ge]);
      assign pe_o_d[ge]  = porte_latch_q[ge] & ~porte_keymatrix_select_q[ge];
      // Key input forces pull-up, key output has none; without key select the enable holds in either mode
      assign pe_pu_d[ge] = (porte_keymatrix_select_q[ge] & ~porte_direction_q[ge]) |
                           (~porte_keymatrix_select_q[ge] & porte_pullup_enable_q[ge]);
      assign pe_wake[ge] = porte_keymatrix_select_q[ge] & ~porte_direction_q[ge] &
                           ~pe_s2_q[ge];
    end
  endgenerate

  // Port A pin control per bit; resistors only while the bit is an input
  genvar ga;
  generate
    for (ga = 0; ga < 3; ga++) begin : g_pa
      logic in_res;
      assign in_res      = ~porta_direction_q[ga] & porta_resistor_enable_q[ga];
      assign pa_oe_d[ga] = porta_direction_q[ga] &
                           (~porta_keymatrix_select_q[ga] | ~porta_latch_q[ga]);
      assign pa_o_d[ga]  = porta_latch_q[ga] & ~porta_keymatrix_select_q[ga];
      assign pa_pu_d[ga] = in_res & ~polarity_cfg_q[ga];
      assign pa_pd_d[ga] = in_res & polarity_cfg_q[ga];
      assign pa_wake[ga] = porta_keymatrix_select_q[ga] & ~porta_direction_q[ga] &
                           (pa_s2_q[ga] == polarity_cfg_q[ga]);
    end
  endgenerate

  // Port B fields and wake; no pulls while the pin serves the interrupt
  assign pb_res  = polarity_cfg_q[`KGP_B_RES_BIT];
  assign pb_key  = polarity_cfg_q[`KGP_B_KEY_BIT];
  assign pb_hl   = polarity_cfg_q[`KGP_B_HL_BIT];
  assign pb_wake = ~shared_pin_select_q & pb_key & (pb_s2_q == pb_hl);
  assign wake_d  = (|pe_wake) | (|pa_wake) | pb_wake;
  assign edge_d  = shared_pin_select_q & (pb_s2_q ^ pb_s3_q);

  // Registered pin controls; one clock from config change to pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      porte_pin_o    <= 4'h0;
      porte_pin_oe   <= 4'h0;
      porte_pullup   <= 4'h0;
      porta_pin_o    <= 3'h0;
      porta_pin_oe   <= 3'h0;
      porta_pullup   <= 3'h0;
      porta_pulldown <= 3'h0;
      portb_pullup   <= 1'b0;
      portb_pulldown <= 1'b0;
    end else begin
      porte_pin_o    <= pe_o_d;
      porte_pin_oe   <= pe_oe_d;
      porte_pullup   <= pe_pu_d;
      porta_pin_o    <= pa_o_d;
      porta_pin_oe   <= pa_oe_d;
      porta_pullup   <= pa_pu_d;
      porta_pulldown <= pa_pd_d;
      portb_pullup   <= ~shared_pin_select_q & pb_res & ~pb_hl;
      portb_pulldown <= ~shared_pin_select_q & pb_res & pb_hl;
    end
  end

  // Wake level and interrupt edge pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      standby_release <= 1'b0;
      ext_int_edge    <= 1'b0;
    end else begin
      standby_release <= wake_d;
      ext_int_edge    <= edge_d;
    end
  end

  property p_e_push;
    @(posedge ref_clk) disable iff (!rst_n)
      (porte_direction_q[0] && !porte_keymatrix_select_q[0]) |=>
        porte_pin_oe[0] && (porte_pin_o[0] == $past(porte_latch_q[0]));
  endproperty
  a_e_push: assert property (p_e_push) else $error("port E push-pull wrong");

  property p_e_od;
    @(posedge ref_clk) disable iff (!rst_n)
      (porte_direction_q[1] && porte_keymatrix_select_q[1]) |=>
        !porte_pin_o[1] && (porte_pin_oe[1] == !$past(porte_latch_q[1]));
  endproperty
  a_e_od: assert property (p_e_od) else $error("port E open drain wrong");

  property p_e_in;
    @(posedge ref_clk) disable iff (!rst_n)
      !porte_direction_q[2] |=> !porte_pin_oe[2];
  endproperty
  a_e_in: assert property (p_e_in) else $error("port E input driven");

  property p_e_keypu;
    @(posedge ref_clk) disable iff (!rst_n)
      (!porte_direction_q[3] && porte_keymatrix_select_q[3]) |=> porte_pullup[3];
  endproperty
  a_e_keypu: assert property (p_e_keypu) else $error("key input lacks pull-up");

  property p_e_pukeep;
    @(posedge ref_clk) disable iff (!rst_n)
      (!porte_keymatrix_select_q[0] && porte_pullup_enable_q[0]) |=> porte_pullup[0];
  endproperty
  a_e_pukeep: assert property (p_e_pukeep) else $error("pull-up dropped");

  property p_e_read;
    @(posedge ref_clk) disable iff (!rst_n)
      dm_e_hit |=> dm_rdata == $past(porte_view);
  endproperty
  a_e_read: assert property (p_e_read) else $error("port E read wrong");

  property p_a_pd;
    @(posedge ref_clk) disable iff (!rst_n)
      (!porta_direction_q[0] && porta_resistor_enable_q[0] && polarity_cfg_q[0]) |=>
        porta_pulldown[0] && !porta_pullup[0];
  endproperty
  a_a_pd: assert property (p_a_pd) else $error("port A pull-down wrong");

  property p_b_noout;
    @(posedge ref_clk) disable iff (!rst_n)
      shared_pin_select_q |=> !portb_pullup && !portb_pulldown;
  endproperty
  a_b_noout: assert property (p_b_noout) else $error("port B active as interrupt");

  property p_b_intread;
    @(posedge ref_clk) disable iff (!rst_n)
      (shared_pin_select_q && dm_b_hit) |=> dm_rdata == `KGP_NIB_ZERO;
  endproperty
  a_b_intread: assert property (p_b_intread) else $error("port B read as interrupt");

  property p_int_edge;
    @(posedge ref_clk) disable iff (!rst_n)
      (shared_pin_select_q && $changed(pb_s2_q)) |=> ext_int_edge;
  endproperty
  a_int_edge: assert property (p_int_edge) else $error("edge not flagged");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (porte_keymatrix_select_q[0] && !porte_direction_q[0] && !pe_s2_q[0]) |=>
        standby_release;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_rst;
    @(posedge ref_clk)
      !rst_n |=> !(|porte_pin_oe) && !(|porte_pullup) && !(|porta_pin_oe) &&
        !(|porta_pullup) && !(|porta_pulldown) && !portb_pullup && !portb_pulldown &&
        !shared_pin_select_q;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");

  property p_a_push;
    @(posedge ref_clk) disable iff (!rst_n)
      (porta_direction_q[1] && !porta_keymatrix_select_q[1]) |=>
        porta_pin_oe[1] && (porta_pin_o[1] == $past(porta_latch_q[1]));
  endproperty
  a_a_push: assert property (p_a_push) else $error("port A push-pull wrong");

  property p_a_od;
    @(posedge ref_clk) disable iff (!rst_n)
      (porta_direction_q[2] && porta_keymatrix_select_q[2]) |=>
        !porta_pin_o[2] && (porta_pin_oe[2] == !$past(porta_latch_q[2]));
  endproperty
  a_a_od: assert property (p_a_od) else $error("port A open drain wrong");

  property p_a_pu;
    @(posedge ref_clk) disable iff (!rst_n)
      (!porta_direction_q[2] && porta_resistor_enable_q[2] && !polarity_cfg_q[2]) |=>
        porta_pullup[2] && !porta_pulldown[2];
  endproperty
  a_a_pu: assert property (p_a_pu) else $error("port A pull-up wrong");

  property p_a_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (porta_keymatrix_select_q[1] && !porta_direction_q[1] &&
        (pa_s2_q[1] == polarity_cfg_q[1])) |=> standby_release;
  endproperty
  a_a_wake: assert property (p_a_wake) else $error("port A wake missed");

  property p_b_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (!shared_pin_select_q && pb_key && (pb_s2_q == pb_hl)) |=> standby_release;
  endproperty
  a_b_wake: assert property (p_b_wake) else $error("port B wake missed");

  property p_b_pull;
    @(posedge ref_clk) disable iff (!rst_n)
      (!shared_pin_select_q && pb_res) |=>
        (portb_pullup == !$past(pb_hl)) && (portb_pulldown == $past(pb_hl));
  endproperty
  a_b_pull: assert property (p_b_pull) else $error("port B pull wrong");

  property p_plain_nowake;
    @(posedge ref_clk) disable iff (!rst_n)
      (!(|porte_keymatrix_select_q) && !(|porta_keymatrix_select_q) && !pb_key) |=>
        !standby_release;
  endproperty
  a_plain_nowake: assert property (p_plain_nowake) else $error("plain input woke");

endmodule
`default_nettype wire

//--- test/kgp_loads.sv
// Purpose: Pin-side loads for the key-scan ports: keys, pulls and idle lines
// Assumes: Bench sets ext enables and values in place of pressed keys
// Notes: An undriven, unpulled line toggles every clock, so it is never a stable value
`default_nettype none
module kgp_loads (
  input  wire logic       ref_clk,
  input  wire logic [3:0] e_o,
  input  wire logic [3:0] e_oe,
  input  wire logic [3:0] e_pu,
  input  wire logic [3:0] e_en,
  input  wire logic [3:0] e_v,
  output var  logic [3:0] e_pin,
  input  wire logic [2:0] a_o,
  input  wire logic [2:0] a_oe,
  input  wire logic [2:0] a_pu,
  input  wire logic [2:0] a_pd,
  input  wire logic [2:0] a_en,
  input  wire logic [2:0] a_v,
  output var  logic [2:0] a_pin,
  input  wire logic       b_pu,
  input  wire logic       b_pd,
  input  wire logic       b_en,
  input  wire logic       b_v,
  output var  logic       b_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt_q = 1'b0;

  // Floating pattern changes each cycle
  always_ff @(posedge ref_clk) begin
    flt_q <= ~flt_q;
  end

  // Device drive wins, then a key, then a pull, else the line floats
  function automatic logic lvl(input logic oe, o, en, v, pu, pd, f);
    return oe ? o : en ? v : pu ? 1'b1 : pd ? 1'b0 : f;
  endfunction

  // Resolve every pin from all parties
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      e_pin[i] = lvl(e_oe[i], e_o[i], e_en[i], e_v[i], e_pu[i], 1'b0, flt_q);
    end
    for (int i = 0; i < 3; i++) begin
      a_pin[i] = lvl(a_oe[i], a_o[i], a_en[i], a_v[i], a_pu[i], a_pd[i], ~flt_q);
    end
    b_pin = lvl(1'b0, 1'b0, b_en, b_v, b_pu, b_pd, flt_q);
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench for the key-scan ports
// Assumes: Inputs change at the falling edge; reads land one clock later
// Notes: Pin effects are checked after a few clocks of synchroniser delay
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, rst_n, rf_wr, dm_wr, dm_bank, b_pin, b_pu, b_pd, b_en, b_v;
  logic       int_edge, wake;
  logic [5:0] rf_addr;
  logic [6:0] dm_addr;
  logic [3:0] rf_wdata, rf_rdata, dm_wdata, dm_rdata, e_pin, e_o, e_oe, e_pu, e_en, e_v;
  logic [2:0] a_pin, a_o, a_oe, a_pu, a_pd, a_en, a_v;
  int         n_mismatch, tests_run, cyc, n_edge;

  kgp_ports DUT (.ref_clk(ref_clk), .rst_n(rst_n), .rf_wr(rf_wr), .rf_addr(rf_addr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .dm_wr(dm_wr), .dm_bank(dm_bank),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .porte_pin_i(e_pin),
    .porte_pin_o(e_o), .porte_pin_oe(e_oe), .porte_pullup(e_pu), .porta_pin_i(a_pin),
    .porta_pin_o(a_o), .porta_pin_oe(a_oe), .porta_pullup(a_pu), .porta_pulldown(a_pd),
    .shared_pin_i(b_pin), .portb_pullup(b_pu), .portb_pulldown(b_pd),
    .ext_int_edge(int_edge), .standby_release(wake));
  kgp_loads u_loads (.ref_clk(ref_clk), .e_o(e_o), .e_oe(e_oe), .e_pu(e_pu), .e_en(e_en),
    .e_v(e_v), .e_pin(e_pin), .a_o(a_o), .a_oe(a_oe), .a_pu(a_pu), .a_pd(a_pd), .a_en(a_en),
    .a_v(a_v), .a_pin(a_pin), .b_pu(b_pu), .b_pd(b_pd), .b_en(b_en), .b_v(b_v), .b_pin(b_pin));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hung run is cut off by the cycle ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Edge pulses counted at the falling edge, where the registered pulse has settled
  always @(negedge ref_clk) begin
    if (int_edge === 1'b1) n_edge++;
  end

  task automatic complete_run();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic rfw(input logic [5:0] a, input logic [3:0] d);
    @(negedge ref_clk);
    rf_wr = 1'b1;
    rf_addr = a;
    rf_wdata = d;
    @(negedge ref_clk);
    rf_wr = 1'b0;
  endtask

  task automatic rfc(input logic [5:0] a, input logic [3:0] exp);
    @(negedge ref_clk);
    rf_addr = a;
    @(negedge ref_clk);
    chk(rf_rdata, exp);
  endtask

  task automatic dmw(input logic b, input logic [6:0] a, input logic [3:0] d);
    @(negedge ref_clk);
    dm_wr = 1'b1;
    dm_bank = b;
    dm_addr = a;
    dm_wdata = d;
    @(negedge ref_clk);
    dm_wr = 1'b0;
  endtask

  task automatic dmc(input logic b, input logic [6:0] a, input logic [3:0] exp);
    @(negedge ref_clk);
    dm_bank = b;
    dm_addr = a;
    @(negedge ref_clk);
    chk(dm_rdata, exp);
  endtask

  // Everything reads zero after reset; unmapped place drops writes
  task automatic t_reset();
    logic [5:0] adr [8] = '{6'h05, 6'h06, 6'h07, 6'h16, 6'h17, 6'h1F, 6'h25, 6'h27};
    foreach (adr[i]) rfc(adr[i], 4'h0);
    chk(e_oe | e_pu, 4'h0);
    chk({1'b0, a_oe | a_pu | a_pd}, 4'h0);
    chk({2'b00, b_pu, b_pd}, 4'h0);
    rfw(6'h3C, 4'hF);
    rfc(6'h3C, 4'h0);
    $display("test reset done");
  endtask

  // Port E push-pull and mixed read-back
  task automatic t_e_out();
    dmw(1'b0, 7'h6F, 4'h5);
    rfw(6'h27, 4'hF);
    idle(3);
    chk(e_oe, 4'hF);
    chk(e_o, 4'h5);
    dmc(1'b0, 7'h6F, 4'h5);
    rfw(6'h27, 4'h3);
    e_en = 4'hC;
    e_v = 4'h8;
    idle(4);
    dmc(1'b0, 7'h6F, 4'h9);
    chk({3'b000, wake}, 4'h0);
    e_en = 4'h0;
    $display("test porte output done");
  endtask

  // Port E key matrix: open-drain sources, pulled-up returns, low wakes
  task automatic t_e_key();
    rfw(6'h16, 4'hF);
    // Returns float until the pull-up lands, so wait for that level to clear the synchroniser
    idle(4);
    chk(e_oe, 4'h2);
    chk(e_o, 4'h0);
    chk(e_pu, 4'hC);
    chk({3'b000, wake}, 4'h0);
    e_en = 4'h4;
    e_v = 4'h0;
    idle(4);
    chk({3'b000, wake}, 4'h1);
    e_en = 4'h0;
    idle(4);
    chk({3'b000, wake}, 4'h0);
    rfw(6'h16, 4'h0);
    rfw(6'h27, 4'h0);
    rfw(6'h17, 4'hA);
    idle(3);
    chk(e_pu, 4'hA);
    rfw(6'h27, 4'hF);
    e_en = 4'hF;
    idle(4);
    chk(e_pu, 4'hA);
    chk({3'b000, wake}, 4'h0);
    e_en = 4'h0;
    rfw(6'h27, 4'h0);
    rfw(6'h17, 4'h0);
    $display("test porte key done");
  endtask

  // Port A pulls, key wake levels, outputs and data read
  task automatic t_a();
    rfw(6'h07, 4'h7);
    rfw(6'h05, 4'h2);
    idle(3);
    chk({1'b0, a_pu}, 4'h5);
    chk({1'b0, a_pd}, 4'h2);
    chk({3'b000, wake}, 4'h0);
    rfw(6'h06, 4'h7);
    rfc(6'h06, 4'h7);
    idle(3);
    chk({3'b000, wake}, 4'h0);
    chk({1'b0, a_pu}, 4'h5);
    a_en = 3'h2;
    a_v = 3'h2;
    idle(4);
    chk({3'b000, wake}, 4'h1);
    a_en = 3'h0;
    rfw(6'h06, 4'h0);
    dmw(1'b1, 7'h70, 4'h7);
    rfw(6'h25, 4'h5);
    idle(4);
    chk({1'b0, a_oe}, 4'h5);
    chk({1'b0, a_o & a_oe}, 4'h5);
    chk({1'b0, a_pu}, 4'h0);
    dmc(1'b1, 7'h70, 4'h5);
    rfw(6'h06, 4'h5);
    dmw(1'b1, 7'h70, 4'h2);
    idle(3);
    chk({1'b0, a_oe}, 4'h5);
    // Pin value of an input bit is unused, so only driven bits are judged
    chk({1'b0, a_o & a_oe}, 4'h0);
    rfw(6'h25, 4'h0);
    rfw(6'h06, 4'h0);
    rfw(6'h07, 4'h0);
    $display("test porta done");
  endtask

  // Port B config, wake, read, and hand-over to the interrupt function
  task automatic t_b();
    rfw(6'h05, 4'h1);
    idle(3);
    chk({2'b00, b_pu, b_pd}, 4'h2);
    rfw(6'h05, 4'h5);
    idle(3);
    chk({2'b00, b_pu, b_pd}, 4'h1);
    b_v = 1'b0;
    idle(4);
    chk({3'b000, wake}, 4'h0);
    rfw(6'h05, 4'h6);
    idle(4);
    chk({3'b000, wake}, 4'h0);
    b_v = 1'b1;
    idle(4);
    chk({3'b000, wake}, 4'h1);
    dmc(1'b1, 7'h71, 4'h1);
    rfw(6'h05, 4'h0);
    n_edge = 0;
    b_v = 1'b0;
    idle(8);
    b_v = 1'b1;
    idle(8);
    chk(4'(n_edge), 4'h0);
    rfw(6'h1F, 4'h2);
    rfc(6'h1F, 4'h2);
    b_v = 1'b0;
    idle(8);
    b_v = 1'b1;
    idle(8);
    chk(4'(n_edge), 4'h2);
    dmc(1'b1, 7'h71, 4'h0);
    rfw(6'h1F, 4'h0);
    $display("test portb done");
  endtask

  initial begin
    {rst_n, rf_wr, dm_wr, dm_bank, e_en, e_v, a_en, a_v} = '0;
    {rf_addr, rf_wdata, dm_addr, dm_wdata} = '0;
    {b_en, b_v} = 2'b11;
    {n_mismatch, tests_run, cyc, n_edge} = '0;
    idle(12);
    rst_n = 1'b1;
    t_reset();
    t_e_out();
    t_e_key();
    t_a();
    t_b();
    complete_run();
  end
endmodule
`default_nettype wire
